// *** core/charger_flags_pkg.sv ***
package charger_flags_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	localparam logic [7:0] FAULT_LIVE_STATUS_B_OFS   = 8'h21;
	localparam logic [7:0] CHARGER_EVENT_LATCH_A_OFS = 8'h22;
	localparam logic [7:0] CHARGER_EVENT_LATCH_B_OFS = 8'h23;

	localparam logic [7:0] REG_RESET_VAL = 8'h00;
	localparam logic [7:0] UNMAPPED_VAL  = 8'h00;

	// ----------------------------------------------------------------
	// Field positions of the live fault status register
	// ----------------------------------------------------------------

	localparam int unsigned FLT_SYS_SHORT_BIT    = 7;
	localparam int unsigned FLT_SYS_OVERVOLT_BIT = 6;
	localparam int unsigned FLT_BOOST_OV_BIT     = 5;
	localparam int unsigned FLT_BOOST_UV_BIT     = 4;
	localparam int unsigned FLT_OVERTEMP_BIT     = 2;

	// ----------------------------------------------------------------
	// Field positions of the first event latch register
	// ----------------------------------------------------------------

	localparam int unsigned EVA_CURRENT_LIMIT_BIT = 7;
	localparam int unsigned EVA_VOLTAGE_LIMIT_BIT = 6;
	localparam int unsigned EVA_WATCHDOG_BIT      = 5;
	localparam int unsigned EVA_WEAK_SOURCE_BIT   = 4;
	localparam int unsigned EVA_POWER_GOOD_BIT    = 3;
	localparam int unsigned EVA_INPUT_TWO_BIT     = 2;
	localparam int unsigned EVA_INPUT_ONE_BIT     = 1;
	localparam int unsigned EVA_BUS_PRESENT_BIT   = 0;

	// ----------------------------------------------------------------
	// Field positions of the second event latch register
	// ----------------------------------------------------------------

	localparam int unsigned EVB_CHARGE_STATE_BIT  = 7;
	localparam int unsigned EVB_OPTIMIZER_BIT     = 6;
	localparam int unsigned EVB_BUS_STATE_BIT     = 4;
	localparam int unsigned EVB_THERMAL_REG_BIT   = 2;
	localparam int unsigned EVB_BATT_PRESENT_BIT  = 1;
	localparam int unsigned EVB_CHARGER_DETECT_BIT = 0;

	// ----------------------------------------------------------------
	// Default widths of the multi-bit status codes
	// ----------------------------------------------------------------

	localparam int unsigned CHARGE_STATE_W = 3;
	localparam int unsigned OPTIMIZER_W    = 2;
	localparam int unsigned BUS_STATE_W    = 4;
	localparam int unsigned DETECT_STATE_W = 4;

endpackage

// *** core/level_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser with a settled level; a change is accepted
// only once the second and third stages agree, which filters a one-cycle
// glitch that slips through metastability resolution.
module level_sync3 #(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_b,
	// Asynchronous levels
	input  wire logic [WIDTH-1:0] async_in,
	// Settled level and change pulse
	output logic      [WIDTH-1:0] level_reg,
	output logic      [WIDTH-1:0] change,
	output logic      [WIDTH-1:0] rise
);

	// Elaboration refuses a zero width, which would leave every vector empty.
	if (WIDTH < 1) begin
		$error("level_sync3 needs a width of at least one");
	end

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] confirm_reg;
	logic [WIDTH-1:0] agree;

	// Only the second stage ever reads the first one.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg    <= '0;
			sync_reg    <= '0;
			confirm_reg <= '0;
		end else begin
			meta_reg    <= async_in;
			sync_reg    <= meta_reg;
			confirm_reg <= sync_reg;
		end
	end

	// A bit is settled when its second and third stages hold the same value.
	assign agree  = ~(sync_reg ^ confirm_reg);
	assign change = agree & (confirm_reg ^ level_reg);
	assign rise   = change & confirm_reg;

	// The settled level follows the third stage only on agreement.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			level_reg <= '0;
		end else begin
			level_reg <= (level_reg & ~agree) | (confirm_reg & agree);
		end
	end

endmodule

`default_nettype wire

// *** core/charger_fault_and_event_flags.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Three eight-bit registers, all zero after reset.
// - Fault bit 7 mirrors system rail short.
// - Fault bit 5 mirrors boost output overvoltage.
// - Fault bit 4 mirrors boost output undervoltage.
// - Fault bit 2 mirrors die thermal shutdown.
// - First latch bit 6 on voltage-limit rise.
// - First latch bit 5 on watchdog expiry rise.
// - First latch bit 4 on weak source rise.
// - First latch bit 3 on power-good change.
// - First latch bit 2 on input two change.
// - Second latch bit 7 on charge state change.
// - Second latch bit 6 on optimizer status change.
// - Bit 4 on bus state change; 5, 3 zero.
// - Second latch bit 2 on thermal regulation rise.
// - Second latch bit 1 on battery presence change.
// - Second latch bit 0 on charger detect change.
module charger_fault_and_event_flags #(
	parameter int unsigned CHARGE_STATE_W = charger_flags_pkg::CHARGE_STATE_W,
	parameter int unsigned OPTIMIZER_W    = charger_flags_pkg::OPTIMIZER_W,
	parameter int unsigned BUS_STATE_W    = charger_flags_pkg::BUS_STATE_W,
	parameter int unsigned DETECT_STATE_W = charger_flags_pkg::DETECT_STATE_W
) (
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rst_b,
	// Register read port from the serial interface engine
	input  wire logic                      rd_en,
	input  wire logic [7:0]                rd_addr,
	output logic      [7:0]                rd_data,
	output logic                           rd_valid,
	// Live protection levels
	input  wire logic                      sys_rail_short_status,
	input  wire logic                      sys_rail_overvolt_status,
	input  wire logic                      boost_out_overvolt_status,
	input  wire logic                      boost_out_undervolt_status,
	input  wire logic                      die_overtemp_shutdown_status,
	// Regulation, timer and source levels
	input  wire logic                      input_current_limit,
	input  wire logic                      input_voltage_limit,
	input  wire logic                      watchdog_expired,
	input  wire logic                      weak_source,
	input  wire logic                      power_good_status,
	input  wire logic                      input_two_present,
	input  wire logic                      input_one_present,
	input  wire logic                      bus_input_present,
	input  wire logic                      thermal_regulation,
	input  wire logic                      battery_present,
	// Multi-bit status codes
	input  wire logic [CHARGE_STATE_W-1:0] charge_state,
	input  wire logic [OPTIMIZER_W-1:0]    input_current_optimizer,
	input  wire logic [BUS_STATE_W-1:0]    bus_input_state,
	input  wire logic [DETECT_STATE_W-1:0] charger_detect_state
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------

	if (CHARGE_STATE_W < 1 || OPTIMIZER_W < 1 || BUS_STATE_W < 1 || DETECT_STATE_W < 1) begin
		$error("status code widths must be at least one bit");
	end

	// ----------------------------------------------------------------
	// Positions of the single-bit levels in the synchroniser vector
	// ----------------------------------------------------------------

	localparam int unsigned LV_SYS_SHORT  = 0;
	localparam int unsigned LV_SYS_OV     = 1;
	localparam int unsigned LV_BOOST_OV   = 2;
	localparam int unsigned LV_BOOST_UV   = 3;
	localparam int unsigned LV_OVERTEMP   = 4;
	localparam int unsigned LV_CUR_LIMIT  = 5;
	localparam int unsigned LV_VOLT_LIMIT = 6;
	localparam int unsigned LV_WATCHDOG   = 7;
	localparam int unsigned LV_WEAK_SRC   = 8;
	localparam int unsigned LV_PGOOD      = 9;
	localparam int unsigned LV_IN_TWO     = 10;
	localparam int unsigned LV_IN_ONE     = 11;
	localparam int unsigned LV_BUS_PRES   = 12;
	localparam int unsigned LV_THERM_REG  = 13;
	localparam int unsigned LV_BATT_PRES  = 14;
	localparam int unsigned LV_COUNT      = 15;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------

	logic [LV_COUNT-1:0]       lv_async;
	logic [LV_COUNT-1:0]       lv_level;
	logic [LV_COUNT-1:0]       lv_change;
	logic [LV_COUNT-1:0]       lv_rise;
	logic [CHARGE_STATE_W-1:0] chg_change;
	logic [OPTIMIZER_W-1:0]    opt_change;
	logic [BUS_STATE_W-1:0]    bus_change;
	logic [DETECT_STATE_W-1:0] det_change;
	logic [7:0]                fault_live;
	logic [7:0]                set_a;
	logic [7:0]                set_b;
	logic                      clr_a;
	logic                      clr_b;
	logic [7:0]                latch_a_reg;
	logic [7:0]                latch_a_next;
	logic [7:0]                latch_b_reg;
	logic [7:0]                latch_b_next;
	logic [7:0]                rd_data_next;

	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------

	// Every source comes from an analog or timer domain, so all pass three flops.
	assign lv_async = {
		battery_present,
		thermal_regulation,
		bus_input_present,
		input_one_present,
		input_two_present,
		power_good_status,
		weak_source,
		watchdog_expired,
		input_voltage_limit,
		input_current_limit,
		die_overtemp_shutdown_status,
		boost_out_undervolt_status,
		boost_out_overvolt_status,
		sys_rail_overvolt_status,
		sys_rail_short_status
	};

	level_sync3 #(.WIDTH(LV_COUNT)) u_sync_levels (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.async_in  (lv_async),
		.level_reg (lv_level),
		.change    (lv_change),
		.rise      (lv_rise)
	);

	// Codes are synchronised per bit; a change in any bit counts as one event.
	level_sync3 #(.WIDTH(CHARGE_STATE_W)) u_sync_charge (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.async_in  (charge_state),
		.level_reg (),
		.change    (chg_change),
		.rise      ()
	);
	level_sync3 #(.WIDTH(OPTIMIZER_W)) u_sync_optimizer (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.async_in  (input_current_optimizer),
		.level_reg (),
		.change    (opt_change),
		.rise      ()
	);
	level_sync3 #(.WIDTH(BUS_STATE_W)) u_sync_bus (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.async_in  (bus_input_state),
		.level_reg (),
		.change    (bus_change),
		.rise      ()
	);
	level_sync3 #(.WIDTH(DETECT_STATE_W)) u_sync_detect (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.async_in  (charger_detect_state),
		.level_reg (),
		.change    (det_change),
		.rise      ()
	);

	// ----------------------------------------------------------------
	// Live fault status
	// ----------------------------------------------------------------

	// Reserved positions stay zero because nothing drives them.
	always_comb begin
		fault_live = charger_flags_pkg::REG_RESET_VAL;
		fault_live[charger_flags_pkg::FLT_SYS_SHORT_BIT]    = lv_level[LV_SYS_SHORT];
		fault_live[charger_flags_pkg::FLT_SYS_OVERVOLT_BIT] = lv_level[LV_SYS_OV];
		fault_live[charger_flags_pkg::FLT_BOOST_OV_BIT]     = lv_level[LV_BOOST_OV];
		fault_live[charger_flags_pkg::FLT_BOOST_UV_BIT]     = lv_level[LV_BOOST_UV];
		fault_live[charger_flags_pkg::FLT_OVERTEMP_BIT]     = lv_level[LV_OVERTEMP];
	end

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------

	// Regulation and timer bits latch on rising edges only; presence bits on any change.
	always_comb begin
		set_a = '0;
		set_a[charger_flags_pkg::EVA_CURRENT_LIMIT_BIT] = lv_rise[LV_CUR_LIMIT];
		set_a[charger_flags_pkg::EVA_VOLTAGE_LIMIT_BIT] = lv_rise[LV_VOLT_LIMIT];
		set_a[charger_flags_pkg::EVA_WATCHDOG_BIT]      = lv_rise[LV_WATCHDOG];
		set_a[charger_flags_pkg::EVA_WEAK_SOURCE_BIT]   = lv_rise[LV_WEAK_SRC];
		set_a[charger_flags_pkg::EVA_POWER_GOOD_BIT]    = lv_change[LV_PGOOD];
		set_a[charger_flags_pkg::EVA_INPUT_TWO_BIT]     = lv_change[LV_IN_TWO];
		set_a[charger_flags_pkg::EVA_INPUT_ONE_BIT]     = lv_change[LV_IN_ONE];
		set_a[charger_flags_pkg::EVA_BUS_PRESENT_BIT]   = lv_change[LV_BUS_PRES];
	end

	// Bits 5 and 3 have no source and therefore never set.
	always_comb begin
		set_b = '0;
		set_b[charger_flags_pkg::EVB_CHARGE_STATE_BIT]   = |chg_change;
		set_b[charger_flags_pkg::EVB_OPTIMIZER_BIT]      = |opt_change;
		set_b[charger_flags_pkg::EVB_BUS_STATE_BIT]      = |bus_change;
		set_b[charger_flags_pkg::EVB_THERMAL_REG_BIT]    = lv_rise[LV_THERM_REG];
		set_b[charger_flags_pkg::EVB_BATT_PRESENT_BIT]   = lv_change[LV_BATT_PRES];
		set_b[charger_flags_pkg::EVB_CHARGER_DETECT_BIT] = |det_change;
	end

	// ----------------------------------------------------------------
	// Sticky latches, cleared by a read
	// ----------------------------------------------------------------

	assign clr_a = rd_en && (rd_addr == charger_flags_pkg::CHARGER_EVENT_LATCH_A_OFS);
	assign clr_b = rd_en && (rd_addr == charger_flags_pkg::CHARGER_EVENT_LATCH_B_OFS);

	// A set in the read cycle survives the clear, so no event is lost between reads.
	assign latch_a_next = (clr_a ? '0 : latch_a_reg) | set_a;
	assign latch_b_next = (clr_b ? '0 : latch_b_reg) | set_b;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			latch_a_reg <= charger_flags_pkg::REG_RESET_VAL;
		end else begin
			latch_a_reg <= latch_a_next;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			latch_b_reg <= charger_flags_pkg::REG_RESET_VAL;
		end else begin
			latch_b_reg <= latch_b_next;
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------

	// Read data shows the value before the clear takes effect.
	always_comb begin
		case (rd_addr)
			charger_flags_pkg::FAULT_LIVE_STATUS_B_OFS: begin
				rd_data_next = fault_live;
			end
			charger_flags_pkg::CHARGER_EVENT_LATCH_A_OFS: begin
				rd_data_next = latch_a_reg;
			end
			charger_flags_pkg::CHARGER_EVENT_LATCH_B_OFS: begin
				rd_data_next = latch_b_reg;
			end
			default: begin
				rd_data_next = charger_flags_pkg::UNMAPPED_VAL;
			end
		endcase
	end

	// Data holds until the next read so the serial engine may shift it out slowly.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data  <= charger_flags_pkg::REG_RESET_VAL;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
			if (rd_en) begin
				rd_data <= rd_data_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	// A read of the status register returns the settled levels in place.
	AST_FAULT_SHORT_BIT: assert property (
		rd_en && rd_addr == charger_flags_pkg::FAULT_LIVE_STATUS_B_OFS
		|=> rd_valid && rd_data[7] == $past(lv_level[LV_SYS_SHORT])
	) else $error("fault bit 7 does not show the short level");
	AST_FAULT_BOOST_BITS: assert property (
		rd_en && rd_addr == charger_flags_pkg::FAULT_LIVE_STATUS_B_OFS
		|=> rd_data[5:4] == $past({lv_level[LV_BOOST_OV], lv_level[LV_BOOST_UV]})
	) else $error("fault bits 5 and 4 do not show the boost levels");
	AST_FAULT_OVERTEMP_BIT: assert property (
		rd_en && rd_addr == charger_flags_pkg::FAULT_LIVE_STATUS_B_OFS
		|=> rd_data[2] == $past(lv_level[LV_OVERTEMP]) && rd_data[6] == $past(lv_level[LV_SYS_OV])
	) else $error("fault bits 6 or 2 do not show their levels");
	AST_FAULT_RESERVED: assert property (
		rd_valid && $past(rd_addr) == charger_flags_pkg::FAULT_LIVE_STATUS_B_OFS
		|-> rd_data[3] == 1'b0 && rd_data[1:0] == 2'b00
	) else $error("reserved fault bits read non-zero");

	// A rise after a settled low latches within five edges; a one-cycle dip is filtered.
	AST_VOLTAGE_LIMIT_LATCH: assert property (
		!input_voltage_limit [*2] ##1 input_voltage_limit [*5]
		|-> latch_a_reg[charger_flags_pkg::EVA_VOLTAGE_LIMIT_BIT]
	) else $error("voltage limit rise was not latched");

	AST_WATCHDOG_FALL_IGNORED: assert property (
		lv_change[LV_WATCHDOG] && !lv_rise[LV_WATCHDOG] && !latch_a_reg[5]
		|=> !latch_a_reg[charger_flags_pkg::EVA_WATCHDOG_BIT]
	) else $error("watchdog fall set the flag");

	AST_POWER_GOOD_CHANGE: assert property (
		lv_change[LV_PGOOD] |=> latch_a_reg[charger_flags_pkg::EVA_POWER_GOOD_BIT]
	) else $error("power good change was not latched");

	AST_STICKY_UNTIL_READ: assert property (
		latch_a_reg[charger_flags_pkg::EVA_INPUT_TWO_BIT] && !clr_a
		|=> latch_a_reg[charger_flags_pkg::EVA_INPUT_TWO_BIT]
	) else $error("event bit dropped without a read");

	AST_CLEAR_ON_READ: assert property (
		clr_b && set_b == 8'h00 |=> latch_b_reg == 8'h00 ##0 rd_data == $past(latch_b_reg)
	) else $error("read did not return and clear the second latch");

	AST_SET_WINS_CLEAR: assert property (
		clr_a && set_a[charger_flags_pkg::EVA_BUS_PRESENT_BIT]
		|=> latch_a_reg[charger_flags_pkg::EVA_BUS_PRESENT_BIT]
	) else $error("event lost in the read cycle");

	AST_RESERVED_LATCH_B: assert property (
		latch_b_reg[5] == 1'b0 && latch_b_reg[3] == 1'b0
	) else $error("reserved event bits set");

	AST_CHARGE_STATE_CHANGE: assert property (
		|chg_change |=> latch_b_reg[charger_flags_pkg::EVB_CHARGE_STATE_BIT]
	) else $error("charge state change was not latched");

	AST_RESET_ZERO: assert property (
		$rose(rst_b) |-> latch_a_reg == 8'h00 && latch_b_reg == 8'h00
	) else $error("registers not zero after reset");

	COV_READ_FAULT: cover property (
		rd_en && rd_addr == charger_flags_pkg::FAULT_LIVE_STATUS_B_OFS ##1 rd_data != 8'h00
	);
	COV_READ_CLEARS_A: cover property (
		latch_a_reg != 8'h00 ##0 clr_a ##1 latch_a_reg == 8'h00
	);
	COV_SET_DURING_READ: cover property (
		clr_b && set_b != 8'h00
	);
	COV_UNMAPPED_READ: cover property (
		rd_en && rd_addr == 8'h24
	);

endmodule

`default_nettype wire

// *** bench/host_reader.sv ***
`timescale 1ns/1ps
`default_nettype none

// Host-side model of the serial engine that issues register reads.
module host_reader (
	// Clock
	input  wire logic       sys_clk,
	// Read request
	output logic            rd_en,
	output logic      [7:0] rd_addr,
	// Read answer
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_valid
);

	// Idle levels from time zero, so the design never sees an unknown strobe.
	initial begin
		rd_en   = 1'b0;
		rd_addr = 8'h00;
	end

	// One read: the strobe stands for a single edge, since a longer one would clear twice.
	// The address is inverted after release, so a design that samples it late sees junk.
	// The answer is taken just after the edge that raised it, where it has settled, and one
	// more edge passes so that a following call never drives the strobe twice in one step.
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output bit ok);
		int n;
		ok      = 1'b0;
		data    = 8'h00;
		rd_en   = 1'b1;
		rd_addr = addr;
		@(posedge sys_clk);
		#1;
		rd_en   = 1'b0;
		rd_addr = ~addr;
		for (n = 0; n < 4 && !ok; n++) begin
			if (rd_valid === 1'b1) begin
				data = rd_data;
				ok   = 1'b1;
			end else begin
				@(posedge sys_clk);
				#1;
			end
		end
		@(posedge sys_clk);
		#1;
	endtask

endmodule

`default_nettype wire

// *** bench/test_charger_fault_and_event_flags.sv ***
`timescale 1ns/1ps
`default_nettype none

module test_charger_fault_and_event_flags;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------

	logic                                        sys_clk = 1'b0;
	logic                                        rst_b   = 1'b0;
	logic                                        rd_en;
	logic [7:0]                                  rd_addr;
	logic [7:0]                                  rd_data;
	logic                                        rd_valid;
	logic [14:0]                                 lv      = '0;
	logic [charger_flags_pkg::CHARGE_STATE_W-1:0] chg_st = '0;
	logic [charger_flags_pkg::OPTIMIZER_W-1:0]    opt_st = '0;
	logic [charger_flags_pkg::BUS_STATE_W-1:0]    bus_st = '0;
	logic [charger_flags_pkg::DETECT_STATE_W-1:0] det_st = '0;
	int                                          error_cnt = 0;
	int                                          checks    = 0;

	// Fault levels expected at the live register, one per level input.
	localparam logic [7:0] FLT_EXP [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04};

	// Free-running clock at 100 MHz.
	always #5 sys_clk = ~sys_clk;

	// ----------------------------------------------------------------
	// Design and host model
	// ----------------------------------------------------------------

	charger_fault_and_event_flags charger_fault_and_event_flags_inst (
		.sys_clk                      (sys_clk),
		.rst_b                        (rst_b),
		.rd_en                        (rd_en),
		.rd_addr                      (rd_addr),
		.rd_data                      (rd_data),
		.rd_valid                     (rd_valid),
		.sys_rail_short_status        (lv[0]),
		.sys_rail_overvolt_status     (lv[1]),
		.boost_out_overvolt_status    (lv[2]),
		.boost_out_undervolt_status   (lv[3]),
		.die_overtemp_shutdown_status (lv[4]),
		.input_current_limit          (lv[5]),
		.input_voltage_limit          (lv[6]),
		.watchdog_expired             (lv[7]),
		.weak_source                  (lv[8]),
		.power_good_status            (lv[9]),
		.input_two_present            (lv[10]),
		.input_one_present            (lv[11]),
		.bus_input_present            (lv[12]),
		.thermal_regulation           (lv[13]),
		.battery_present              (lv[14]),
		.charge_state                 (chg_st),
		.input_current_optimizer      (opt_st),
		.bus_input_state              (bus_st),
		.charger_detect_state         (det_st)
	);

	host_reader host_reader_inst (
		.sys_clk  (sys_clk),
		.rd_en    (rd_en),
		.rd_addr  (rd_addr),
		.rd_data  (rd_data),
		.rd_valid (rd_valid)
	);

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------

	// Counts every comparison; case inequality keeps an unknown from passing.
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Steps past n edges and lands just after the last, where inputs may change.
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Reads one register and compares; a missing answer ends the run.
	task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
		logic [7:0] d;
		bit         ok;
		host_reader_inst.read_reg(adr, d, ok);
		chk("rd_valid", {7'h00, ok}, 8'h01);
		if (!ok)
			end_sim();
		else
			chk($sformatf("reg_%h", adr), d, exp);
	endtask

	// Waits out the synchroniser, reads, and for a latch register reads again to see it clear.
	task automatic settle_rd(input logic [7:0] adr, input logic [7:0] exp);
		tick(4);
		rd(adr, exp);
		if (adr != 8'h21)
			rd(adr, 8'h00);
	endtask

	// Moves one level input, then checks the register that reports it.
	task automatic ev(input int idx, input logic v, input logic [7:0] adr, input logic [7:0] exp);
		lv[idx] = v;
		settle_rd(adr, exp);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------

	// Reset values, and addresses outside the map that must read as zero.
	task automatic t_reset();
		rd(8'h21, 8'h00);
		rd(8'h22, 8'h00);
		rd(8'h23, 8'h00);
		rd(8'h24, 8'h00);
		rd(8'hFF, 8'h00);
		$display("test reset done");
	endtask

	// Each fault alone, then all together, which also shows the reserved bits stay low.
	task automatic t_fault();
		for (int i = 0; i < 5; i++) begin
			ev(i, 1'b1, 8'h21, FLT_EXP[i]);
			ev(i, 1'b0, 8'h21, 8'h00);
		end
		lv[4:0] = 5'h1F;
		settle_rd(8'h21, 8'hF4);
		lv[4:0] = 5'h00;
		settle_rd(8'h21, 8'h00);
		$display("test fault done");
	endtask

	// Rise-only events: a rise sets the flag, the fall that follows must not.
	task automatic t_rise();
		for (int i = 0; i < 4; i++) begin
			ev(5 + i, 1'b1, 8'h22, 8'h80 >> i);
			ev(5 + i, 1'b0, 8'h22, 8'h00);
		end
		ev(13, 1'b1, 8'h23, 8'h04);
		ev(13, 1'b0, 8'h23, 8'h00);
		$display("test rise done");
	endtask

	// Change events: both directions set the flag.
	task automatic t_change();
		for (int i = 0; i < 4; i++) begin
			ev(9 + i, 1'b1, 8'h22, 8'h08 >> i);
			ev(9 + i, 1'b0, 8'h22, 8'h08 >> i);
		end
		ev(14, 1'b1, 8'h23, 8'h02);
		ev(14, 1'b0, 8'h23, 8'h02);
		$display("test change done");
	endtask

	// Multi-bit status codes: any change of the code is one event.
	task automatic t_codes();
		chg_st = ~chg_st;
		settle_rd(8'h23, 8'h80);
		opt_st = ~opt_st;
		settle_rd(8'h23, 8'h40);
		bus_st = ~bus_st;
		settle_rd(8'h23, 8'h10);
		det_st = ~det_st;
		settle_rd(8'h23, 8'h01);
		$display("test codes done");
	endtask

	// A flag must survive reads of the other registers and clear only on its own.
	task automatic t_hold();
		lv[7] = 1'b1;
		tick(4);
		rd(8'h23, 8'h00);
		rd(8'h21, 8'h00);
		tick(20);
		rd(8'h22, 8'h20);
		rd(8'h22, 8'h00);
		lv[7] = 1'b0;
		$display("test hold done");
	endtask

	// A mid-run reset drops a pending flag; levels still high at release are new events,
	// and the presence event lands in the cycle of a read, where it must survive the clear.
	task automatic t_rst_mid();
		lv[12] = 1'b1;
		tick(4);
		rst_b = 1'b0;
		tick(2);
		rst_b = 1'b1;
		tick(1);
		rd(8'h22, 8'h00);
		rd(8'h22, 8'h00);
		rd(8'h22, 8'h01);
		rd(8'h23, 8'hD1);
		lv[12] = 1'b0;
		settle_rd(8'h22, 8'h01);
		$display("test mid reset done");
	endtask

	// ----------------------------------------------------------------
	// Verdict and main sequence
	// ----------------------------------------------------------------

	// The single place where the run ends.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Reset is held for eight cycles and released just after an edge.
	initial begin
		repeat (8) @(posedge sys_clk);
		#1;
		rst_b = 1'b1;
		tick(2);
		t_reset();
		t_fault();
		t_rise();
		t_change();
		t_codes();
		t_hold();
		t_rst_mid();
		end_sim();
	end

endmodule

`default_nettype wire
